// ===== i2cs_pkg.sv
package i2cs_pkg;

	localparam int unsigned ADDR_W   = 7;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned ITEM_W   = BYTE_W + 1;
	localparam int unsigned RAM_WORDS = 32;
	localparam int unsigned PTR_W    = 5;
	localparam int unsigned BUF_DEPTH = 2;

	// system clock, 250 MHz
	localparam int unsigned CLK_PERIOD_PS = 4000;

	// spike filter width on both bus lines, per selected speed
	localparam int unsigned SPIKE_NS_50K  = 16;
	localparam int unsigned SPIKE_NS_100K = 12;
	localparam int unsigned SPIKE_NS_400K = 8;
	localparam logic [2:0] SPIKE_CYC_50K  = 3'((SPIKE_NS_50K * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [2:0] SPIKE_CYC_100K = 3'((SPIKE_NS_100K * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [2:0] SPIKE_CYC_400K = 3'((SPIKE_NS_400K * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] LAST_RD_BIT   = 3'h7;

	typedef enum logic [1:0] {
		I2CS_SPD_50K,
		I2CS_SPD_100K,
		I2CS_SPD_400K
	} i2cs_speed_t;

	function automatic logic [2:0] i2cs_spike_cycles(input i2cs_speed_t spd);
		case (spd)
			I2CS_SPD_50K:  return SPIKE_CYC_50K;
			I2CS_SPD_100K: return SPIKE_CYC_100K;
			default:       return SPIKE_CYC_400K;
		endcase
	endfunction : i2cs_spike_cycles

	// one step of the glitch filter: returns {filtered level, stable count}
	function automatic logic [3:0] i2cs_filt_step(input logic raw, input logic filt, input logic [2:0] cnt,
		input logic [2:0] need);
		logic [2:0] nc;
		nc = 3'h0;
		if (raw == filt) begin
			return {filt, 3'h0};
		end
		nc = cnt + 3'h1;
		if (nc >= need) begin
			return {raw, 3'h0};
		end
		return {filt, nc};
	endfunction : i2cs_filt_step

endpackage : i2cs_pkg

// ===== i2cs_stream_if.sv
`timescale 1ns/1ps
interface i2cs_stream_if;
	import i2cs_pkg::*;
	logic              valid;
	logic              ready;
	logic [ITEM_W-1:0] data;

	modport src (
		output valid,
		output data,
		input  ready
	);
	modport snk (
		input  valid,
		input  data,
		output ready
	);
endinterface : i2cs_stream_if

// ===== i2cs_buf2.sv
`timescale 1ns/1ps
module i2cs_buf2 (
	input wire logic ref_clk,
	input wire logic rst,
	i2cs_stream_if.snk up,
	i2cs_stream_if.src dn
);
	import i2cs_pkg::*;

	typedef struct packed {
		logic [BUF_DEPTH-1:0][ITEM_W-1:0] mem;
		logic                             wp;
		logic                             rp;
		logic [1:0]                       cnt;
	} i2cs_buf_t;

	i2cs_buf_t q;
	i2cs_buf_t d;
	logic      push;
	logic      pop;

	assign up.ready = (q.cnt != 2'(BUF_DEPTH));
	assign dn.valid = (q.cnt != 2'h0);
	assign dn.data  = q.mem[q.rp];
	assign push     = up.valid & up.ready;
	assign pop      = dn.valid & dn.ready;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = up.data;
			d.wp        = ~q.wp;
		end
		if (pop) begin
			d.rp = ~q.rp;
		end
		d.cnt = q.cnt + 2'(push) - 2'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : i2cs_buf2

// ===== i2cs_top.sv
`timescale 1ns/1ps
//Behaviour
//- The block is a bus slave only, receives and transmits bytes and hands them to the processor one at a time.
//- Start and stop are detected and acknowledge bits are produced by hardware with no processor action.
//- The block works with master clock rates up to 400 kHz.
//- A received 7-bit address is compared against the own address in hardware and only a match is answered.
//- For 10-bit and SMBus use, address and data bytes are passed to firmware, which decides.
//- While enabled the block owns the data and clock pins and general-purpose control of them is off.
//- The processor exchanges data and control through its ports and may poll levels or use event pulses.
//- In default mode the bus clock is held low after each byte until the processor reads or supplies data.
//- In buffered mode the block looks to the master like a 32-byte memory.
//- In buffered mode the first written byte sets the pointer and later accesses use and advance it.
//- In buffered mode the clock line is never held low.
//- In buffered mode the master reads whatever was last stored in the memory, by the processor or by a master write.
//- A monitor mode watches and reports bus activity without ever driving the bus.
//- The bus speed is selectable as 50 kHz, 100 kHz or 400 kHz.
module i2cs_top (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic                        enable,
	input  wire logic                        ram_buffer_mode,
	input  wire logic                        monitor_mode,
	input  wire logic                        hw_addr_en,
	input  wire logic [i2cs_pkg::ADDR_W-1:0] own_addr,
	input  wire i2cs_pkg::i2cs_speed_t       speed_sel,
	input  wire logic                        scl_i,
	output logic                             scl_o,
	output logic                             scl_oe,
	input  wire logic                        sda_i,
	output logic                             sda_o,
	output logic                             sda_oe,
	output logic                             gpio_release,
	output logic                             rx_valid,
	input  wire logic                        rx_ready,
	output logic [i2cs_pkg::BYTE_W-1:0]      rx_data,
	output logic                             rx_is_addr,
	input  wire logic                        tx_valid,
	input  wire logic [i2cs_pkg::BYTE_W-1:0] tx_data,
	output logic                             tx_ready,
	input  wire logic                        cpu_ram_we,
	input  wire logic [i2cs_pkg::PTR_W-1:0]  cpu_ram_addr,
	input  wire logic [i2cs_pkg::BYTE_W-1:0] cpu_ram_wdata,
	output logic [i2cs_pkg::BYTE_W-1:0]      cpu_ram_rdata,
	output logic                             evt_start,
	output logic                             evt_stop,
	output logic                             evt_byte,
	output logic                             bus_busy,
	output logic                             addressed,
	output logic                             read_dir,
	output logic                             bus_stalled
);
	import i2cs_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_HOLD,
		ST_REL,
		ST_WDATA,
		ST_RDATA,
		ST_RACK,
		ST_RNEXT,
		ST_SKIP
	} i2cs_state_t;

	typedef struct packed {
		logic                                scl_m;
		logic                                scl_s;
		logic                                sda_m;
		logic                                sda_s;
		logic                                scl_f;
		logic                                sda_f;
		logic [2:0]                          scl_cnt;
		logic [2:0]                          sda_cnt;
		i2cs_state_t                         st;
		logic [3:0]                          bitcnt;
		logic [BYTE_W-1:0]                   sh;
		logic                                rw;
		logic                                first;
		logic [PTR_W-1:0]                    ptr;
		logic                                sda_low;
		logic                                scl_low;
		logic                                push;
		logic [ITEM_W-1:0]                   push_data;
		logic                                tx_take;
		logic                                evt_start;
		logic                                evt_stop;
		logic                                evt_byte;
		logic                                busy;
		logic                                addressed;
		logic [RAM_WORDS-1:0][BYTE_W-1:0]    ram;
		logic [BYTE_W-1:0]                   cpu_rd;
	} i2cs_top_t;

	i2cs_top_t      q;
	i2cs_top_t      d;
	i2cs_stream_if  rx_up ();
	i2cs_stream_if  rx_dn ();

	// a byte that arrives while the buffer is full is dropped; on writes the bus is held until the buffer drains
	i2cs_buf2 u_buf (
		.ref_clk (ref_clk),
		.rst     (rst),
		.up      (rx_up.snk),
		.dn      (rx_dn.src)
	);

	assign rx_up.valid  = q.push;
	assign rx_up.data   = q.push_data;
	assign rx_valid     = rx_dn.valid;
	assign rx_dn.ready  = rx_ready;
	assign rx_data      = rx_dn.data[BYTE_W-1:0];
	assign rx_is_addr   = rx_dn.data[ITEM_W-1];

	// open drain: only ever pull low
	assign scl_o        = 1'b0;
	assign sda_o        = 1'b0;
	assign scl_oe       = q.scl_low;
	assign sda_oe       = q.sda_low;
	assign gpio_release = enable;
	assign tx_ready     = q.tx_take;
	assign cpu_ram_rdata = q.cpu_rd;
	assign evt_start    = q.evt_start;
	assign evt_stop     = q.evt_stop;
	assign evt_byte     = q.evt_byte;
	assign bus_busy     = q.busy;
	assign addressed    = q.addressed;
	assign read_dir     = q.rw;
	assign bus_stalled  = q.scl_low;

	always_comb begin
		logic [3:0] fs;
		logic [3:0] fd;
		logic [2:0] need;
		logic       nscl;
		logic       nsda;
		logic       rise;
		logic       fall;
		logic       start;
		logic       stop;
		logic       match;
		fs    = 4'h0;
		fd    = 4'h0;
		need  = i2cs_spike_cycles(speed_sel);
		nscl  = 1'b1;
		nsda  = 1'b1;
		rise  = 1'b0;
		fall  = 1'b0;
		start = 1'b0;
		stop  = 1'b0;
		match = 1'b0;
		d           = q;
		d.push      = 1'b0;
		d.tx_take   = 1'b0;
		d.evt_start = 1'b0;
		d.evt_stop  = 1'b0;
		d.evt_byte  = 1'b0;

		d.scl_m = scl_i;
		d.scl_s = q.scl_m;
		d.sda_m = sda_i;
		d.sda_s = q.sda_m;
		fs = i2cs_filt_step(q.scl_s, q.scl_f, q.scl_cnt, need);
		fd = i2cs_filt_step(q.sda_s, q.sda_f, q.sda_cnt, need);
		nscl      = fs[3];
		nsda      = fd[3];
		d.scl_f   = nscl;
		d.sda_f   = nsda;
		d.scl_cnt = fs[2:0];
		d.sda_cnt = fd[2:0];
		// few cycles of latency keep edges well inside a 400 kHz bit time
		rise  = nscl & ~q.scl_f;
		fall  = ~nscl & q.scl_f;
		start = nscl & q.scl_f & q.sda_f & ~nsda;
		stop  = nscl & q.scl_f & ~q.sda_f & nsda;

		if (cpu_ram_we) begin
			d.ram[cpu_ram_addr] = cpu_ram_wdata;
		end
		d.cpu_rd = q.ram[cpu_ram_addr];

		if (!enable) begin
			d.st        = ST_IDLE;
			d.sda_low   = 1'b0;
			d.scl_low   = 1'b0;
			d.busy      = 1'b0;
			d.addressed = 1'b0;
		end else if (start) begin
			d.evt_start = 1'b1;
			d.busy      = 1'b1;
			d.st        = ST_ADDR;
			d.bitcnt    = 4'h0;
			d.sda_low   = 1'b0;
			d.scl_low   = 1'b0;
			d.addressed = 1'b0;
		end else if (stop) begin
			d.evt_stop  = 1'b1;
			d.busy      = 1'b0;
			d.st        = ST_IDLE;
			d.sda_low   = 1'b0;
			d.scl_low   = 1'b0;
			d.addressed = 1'b0;
		end else begin
			unique case (q.st)
				ST_IDLE, ST_SKIP: begin
				end
				ST_ADDR: begin
					if (rise) begin
						d.sh     = {q.sh[BYTE_W-2:0], nsda};
						d.bitcnt = q.bitcnt + 4'h1;
					end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
						d.evt_byte = 1'b1;
						// with compare off every address is taken outside monitor mode and firmware judges it
						match = (!hw_addr_en || q.sh[BYTE_W-1:1] == own_addr) && !monitor_mode;
						if (match) begin
							d.addressed = 1'b1;
							d.rw        = q.sh[0];
							d.first     = 1'b1;
							d.sda_low   = 1'b1;
							d.st        = ST_ACK;
							d.push      = !ram_buffer_mode && rx_up.ready;
							d.push_data = {1'b1, q.sh};
						end else begin
							d.st = ST_SKIP;
						end
					end
				end
				ST_WDATA: begin
					if (rise) begin
						d.sh     = {q.sh[BYTE_W-2:0], nsda};
						d.bitcnt = q.bitcnt + 4'h1;
					end else if (fall && q.bitcnt == BITS_PER_BYTE) begin
						d.evt_byte = 1'b1;
						d.sda_low  = 1'b1;
						d.st       = ST_ACK;
						if (ram_buffer_mode) begin
							if (q.first) begin
								d.ptr   = q.sh[PTR_W-1:0];
								d.first = 1'b0;
							end else begin
								d.ram[q.ptr] = q.sh;
								d.ptr        = q.ptr + PTR_W'(1);
							end
						end else begin
							d.push      = rx_up.ready;
							d.push_data = {1'b0, q.sh};
						end
					end
				end
				ST_ACK: begin
					if (fall) begin
						d.sda_low = 1'b0;
						d.bitcnt  = 4'h0;
						if (!ram_buffer_mode) begin
							d.scl_low = 1'b1;
							d.st      = ST_HOLD;
						end else if (q.rw) begin
							d.sh      = q.ram[q.ptr];
							d.sda_low = ~q.ram[q.ptr][BYTE_W-1];
							d.ptr     = q.ptr + PTR_W'(1);
							d.st      = ST_RDATA;
						end else begin
							d.st = ST_WDATA;
						end
					end
				end
				ST_HOLD: begin
					// clock stays low; data is set here and the clock freed one cycle later
					if (q.rw && tx_valid) begin
						d.sh      = tx_data;
						d.tx_take = 1'b1;
						d.sda_low = ~tx_data[BYTE_W-1];
						d.st      = ST_REL;
					end else if (!q.rw && !rx_dn.valid) begin
						d.st = ST_REL;
					end
				end
				ST_REL: begin
					d.scl_low = 1'b0;
					d.st      = q.rw ? ST_RDATA : ST_WDATA;
				end
				ST_RDATA: begin
					if (fall) begin
						d.bitcnt = q.bitcnt + 4'h1;
						if (q.bitcnt[2:0] == LAST_RD_BIT) begin
							d.sda_low = 1'b0;
							d.st      = ST_RACK;
						end else begin
							d.sh      = {q.sh[BYTE_W-2:0], 1'b0};
							d.sda_low = ~q.sh[BYTE_W-2];
						end
					end
				end
				ST_RACK: begin
					if (rise) begin
						d.evt_byte = 1'b1;
						d.st       = nsda ? ST_SKIP : ST_RNEXT;
					end
				end
				ST_RNEXT: begin
					if (fall) begin
						d.bitcnt = 4'h0;
						if (ram_buffer_mode) begin
							d.sh      = q.ram[q.ptr];
							d.sda_low = ~q.ram[q.ptr][BYTE_W-1];
							d.ptr     = q.ptr + PTR_W'(1);
							d.st      = ST_RDATA;
						end else begin
							d.scl_low = 1'b1;
							d.st      = ST_HOLD;
						end
					end
				end
				default: begin
					d.st      = ST_IDLE;
					d.sda_low = 1'b0;
					d.scl_low = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q       <= '0;
			q.scl_m <= 1'b1;
			q.scl_s <= 1'b1;
			q.sda_m <= 1'b1;
			q.sda_s <= 1'b1;
			q.scl_f <= 1'b1;
			q.sda_f <= 1'b1;
			q.st    <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

endmodule : i2cs_top

// ===== i2cs_top_assertions.sv
`timescale 1ns/1ps
module i2cs_top_checker (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        enable,
	input wire logic        ram_buffer_mode,
	input wire logic        monitor_mode,
	input wire logic        gpio_release,
	input wire logic        scl_oe,
	input wire logic        sda_oe,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic [7:0]  rx_data,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic        evt_start,
	input wire logic        evt_stop,
	input wire logic        bus_busy
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	chk_pin_owner: assert property (gpio_release == enable)
		else $error("pin ownership differs from enable");
	chk_off_quiet: assert property (!enable [*2] |-> !sda_oe && !scl_oe)
		else $error("disabled block pulls a line");
	chk_no_stretch: assert property (ram_buffer_mode && $past(ram_buffer_mode) |-> !scl_oe)
		else $error("clock held low in buffered mode");
	chk_monitor_silent: assert property (monitor_mode && $past(monitor_mode) |-> !sda_oe && !scl_oe)
		else $error("monitor mode drives the bus");
	chk_tx_taken: assert property (tx_ready |-> $past(tx_valid))
		else $error("tx byte taken without offer");
	chk_tx_pulse: assert property (tx_ready |=> !tx_ready)
		else $error("tx_ready longer than one cycle");
	chk_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("stalled rx byte lost or changed");
	chk_start_pulse: assert property (evt_start |-> !evt_stop ##1 !evt_start)
		else $error("start event malformed");
	chk_busy_start: assert property (evt_start |-> ##[0:2] bus_busy)
		else $error("bus not busy after start");
	cov_rx_taken: cover property (rx_valid && rx_ready);
	cov_tx_taken: cover property (tx_ready);
	cov_stop: cover property (evt_stop);
endmodule : i2cs_top_checker

bind i2cs_top i2cs_top_checker i2cs_top_checker_inst (.ref_clk, .rst, .enable, .ram_buffer_mode,
	.monitor_mode, .gpio_release, .scl_oe, .sda_oe, .rx_valid, .rx_ready, .rx_data, .tx_valid,
	.tx_ready, .evt_start, .evt_stop, .bus_busy);

// ===== i2cs_master_model.sv
`timescale 1ns/1ps
module i2cs_master_model (
	output logic      scl_low,
	output logic      sda_low,
	input wire logic  scl_line,
	input wire logic  sda_line
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// also serves as repeated start when the clock is low
	task automatic start_cond();
		sda_low = 1'b0;
		#40;
		scl_low = 1'b0;
		wait (scl_line === 1'b1);
		#40;
		sda_low = 1'b1;
		#40;
		scl_low = 1'b1;
		#40;
	endtask : start_cond
	task automatic clk_bit(input logic b, output logic s);
		sda_low = ~b;
		#40;
		scl_low = 1'b0;
		// the slave may hold the clock low
		wait (scl_line === 1'b1);
		#80;
		s = sda_line;
		scl_low = 1'b1;
		#40;
	endtask : clk_bit
	task automatic stop_cond();
		sda_low = 1'b1;
		#40;
		scl_low = 1'b0;
		wait (scl_line === 1'b1);
		#40;
		sda_low = 1'b0;
		#80;
	endtask : stop_cond
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(ack_in, ack);
	endtask : xfer
endmodule : i2cs_master_model

// ===== i2cs_top_bench.sv
`timescale 1ns/1ps
module i2cs_top_bench;
	import i2cs_pkg::*;
	logic        ref_clk, rst, enable, ram_buffer_mode, monitor_mode, hw_addr_en;
	logic [6:0]  own_addr;
	i2cs_speed_t speed_sel;
	logic        scl_o, scl_oe, sda_o, sda_oe, gpio_release, rx_valid, rx_ready, rx_is_addr;
	logic [7:0]  rx_data, tx_data, cpu_ram_wdata, cpu_ram_rdata, b;
	logic        tx_valid, tx_ready, cpu_ram_we, evt_start, evt_stop, evt_byte;
	logic [4:0]  cpu_ram_addr;
	logic        bus_busy, addressed, read_dir, bus_stalled, m_scl_low, m_sda_low, hs;
	logic [8:0]  rx_q[$], item;
	logic [7:0]  tx_q[$], mem[32];
	int          n_fail = 0, checks_done = 0, n_start = 0, n_start_exp = 0, n_stop = 0;
	bit          rx_chk = 1'b1;
	// open-drain lines with pull-ups
	wire scl_line = ~(m_scl_low | scl_oe);
	wire sda_line = ~(m_sda_low | sda_oe);

	i2cs_top i2cs_top_inst (.ref_clk, .rst, .enable, .ram_buffer_mode, .monitor_mode, .hw_addr_en,
		.own_addr, .speed_sel, .scl_i(scl_line), .scl_o, .scl_oe, .sda_i(sda_line), .sda_o, .sda_oe,
		.gpio_release, .rx_valid, .rx_ready, .rx_data, .rx_is_addr, .tx_valid, .tx_data, .tx_ready,
		.cpu_ram_we, .cpu_ram_addr, .cpu_ram_wdata, .cpu_ram_rdata, .evt_start, .evt_stop, .evt_byte,
		.bus_busy, .addressed, .read_dir, .bus_stalled);
	i2cs_master_model i2cs_master_model_inst (.scl_low(m_scl_low), .sda_low(m_sda_low), .scl_line, .sda_line);

	always #2 ref_clk = ~ref_clk;

	task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h got %h", what, exp, got);
		end
	endtask : cmp

	task automatic finish_test();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	// processor side: random rx stalls, tx bytes offered from a queue
	always @(posedge ref_clk) begin
		if (hs && rx_chk) begin
			if (rx_q.size() == 0) cmp("rx_extra", 9'bx, item);
			else cmp("rx_item", rx_q.pop_front(), item);
		end
		#1;
		if (evt_start === 1'b1) n_start++;
		if (evt_stop === 1'b1) n_stop++;
		if (tx_ready === 1'b1 && tx_q.size() != 0) void'(tx_q.pop_front());
		rx_ready = ($urandom_range(3) != 0);
		tx_valid = (tx_q.size() != 0);
		tx_data = tx_valid ? tx_q[0] : 8'h00;
		hs = (rx_valid === 1'b1) && rx_ready;
		item = {rx_is_addr, rx_data};
	end

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick

	task automatic st();
		if (enable) n_start_exp++;
		i2cs_master_model_inst.start_cond();
	endtask : st

	task automatic put(input logic [7:0] d, input logic exp_ack, input logic is_addr);
		logic [7:0] q;
		logic       ack;
		if (!exp_ack && !ram_buffer_mode) rx_q.push_back({is_addr, d});
		i2cs_master_model_inst.xfer(d, 1'b1, q, ack);
		cmp("ack", {8'h00, exp_ack}, {8'h00, ack});
	endtask : put

	task automatic get(input logic [7:0] exp, input logic from_tx, input logic last);
		logic [7:0] q;
		logic       ack;
		if (from_tx) tx_q.push_back(exp);
		i2cs_master_model_inst.xfer(8'hFF, last, q, ack);
		cmp("rd_byte", {1'b0, exp}, {1'b0, q});
	endtask : get

	initial begin
		void'($urandom(32'h67DD106F));
		ref_clk = 1'b0;
		rst = 1'b1;
		enable = 1'b1;
		ram_buffer_mode = 1'b0;
		monitor_mode = 1'b0;
		hw_addr_en = 1'b1;
		own_addr = 7'($urandom_range(8, 119));
		speed_sel = I2CS_SPD_400K;
		{rx_ready, tx_valid, tx_data, cpu_ram_we, cpu_ram_addr, cpu_ram_wdata, hs} = '0;
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (16) @(posedge ref_clk);
		#1 rst = 1'b0;
		for (int s = 0; s < 3; s++) begin
			tick();
			speed_sel = i2cs_speed_t'(s);
			st();
			put({own_addr, 1'b0}, 1'b0, 1'b1);
			repeat (2) put(8'($urandom), 1'b0, 1'b0);
			i2cs_master_model_inst.stop_cond();
		end
		st();
		put({own_addr ^ 7'h01, 1'b0}, 1'b1, 1'b1);
		put(8'hA5, 1'b1, 1'b0);
		i2cs_master_model_inst.stop_cond();
		st();
		put({own_addr, 1'b1}, 1'b0, 1'b1);
		// no tx byte offered yet, so the clock must be held
		cmp("stalled", 9'h001, {8'h00, bus_stalled});
		cmp("read_dir", 9'h001, {8'h00, read_dir});
		cmp("addressed", 9'h001, {8'h00, addressed});
		get(8'($urandom), 1'b1, 1'b0);
		get(8'($urandom), 1'b1, 1'b1);
		i2cs_master_model_inst.stop_cond();
		tick();
		cmp("busy", 9'h000, {8'h00, bus_busy});
		hw_addr_en = 1'b0;
		st();
		put({own_addr ^ 7'h10, 1'b0}, 1'b0, 1'b1);
		put(8'($urandom), 1'b0, 1'b0);
		i2cs_master_model_inst.stop_cond();
		tick();
		hw_addr_en = 1'b1;
		monitor_mode = 1'b1;
		rx_chk = 1'b0;
		st();
		put({own_addr, 1'b0}, 1'b1, 1'b1);
		i2cs_master_model_inst.stop_cond();
		tick();
		monitor_mode = 1'b0;
		rx_chk = 1'b1;
		ram_buffer_mode = 1'b1;
		st();
		put({own_addr, 1'b0}, 1'b0, 1'b1);
		put(8'hFF, 1'b0, 1'b0);
		b = 8'($urandom);
		mem[31] = b;
		put(b, 1'b0, 1'b0);
		b = 8'($urandom);
		mem[0] = b;
		put(b, 1'b0, 1'b0);
		i2cs_master_model_inst.stop_cond();
		tick();
		cpu_ram_we = 1'b1;
		cpu_ram_addr = 5'h01;
		cpu_ram_wdata = 8'h3C;
		mem[1] = 8'h3C;
		tick();
		cpu_ram_we = 1'b0;
		cpu_ram_addr = 5'h00;
		tick();
		cmp("ram_rd", {1'b0, mem[0]}, {1'b0, cpu_ram_rdata});
		st();
		put({own_addr, 1'b0}, 1'b0, 1'b1);
		put(8'h1F, 1'b0, 1'b0);
		st();
		put({own_addr, 1'b1}, 1'b0, 1'b1);
		for (int i = 0; i < 3; i++) get(mem[(31 + i) % 32], 1'b0, i == 2);
		i2cs_master_model_inst.stop_cond();
		tick();
		ram_buffer_mode = 1'b0;
		enable = 1'b0;
		tick();
		cmp("pin_owner", 9'h000, {8'h00, gpio_release});
		st();
		put({own_addr, 1'b0}, 1'b1, 1'b1);
		i2cs_master_model_inst.stop_cond();
		tick();
		enable = 1'b1;
		repeat (8) tick();
		cmp("starts", 9'(n_start_exp), 9'(n_start));
		// nine stops are issued while enabled; the one while disabled must stay silent
		cmp("stops", 9'h009, 9'(n_stop));
		cmp("rx_left", 9'h000, 9'(rx_q.size()));
		finish_test();
	end

	initial begin
		#300us;
		n_fail++;
		finish_test();
	end
endmodule : i2cs_top_bench
